// File: design/rfn_pkg.sv
package rfn_pkg;
  // ----------------------------------------
  // link word and latch selection
  // ----------------------------------------
  localparam int         WORD_W        = 24;
  localparam logic [1:0] SEL_RF_N      = 2'h3;
  localparam logic [1:0] SEL_IF_N      = 2'h1;
  // ----------------------------------------
  // rf feedback divider word fields
  // ----------------------------------------
  localparam int RF_CLEAR_BIT   = 23;
  localparam int RF_SLEEP_BIT   = 22;
  localparam int PRESC_BIT      = 21;
  localparam int COARSE_LSB     = 10;
  localparam int BCNT_LSB       = 8;
  localparam int ACNT_LSB       = 6;
  localparam int FRAC_LSB       = 2;
  // ----------------------------------------
  // if divider word fields
  // ----------------------------------------
  localparam int IF_CLEAR_BIT   = 23;
  localparam int IF_SLEEP_BIT   = 22;
  localparam int TIMING_BIT     = 21;
  localparam int IF_PROG_LSB    = 5;
  localparam int IF_SWALLOW_LSB = 2;
  // ----------------------------------------
  // divide limits
  // ----------------------------------------
  localparam logic [15:0] BASE_LOW      = 16'h0008;
  localparam logic [15:0] BASE_HIGH     = 16'h0010;
  localparam logic [10:0] MIN_COARSE    = 11'h003;
  localparam logic [10:0] COARSE_MARGIN = 11'h002;
  localparam logic [11:0] IF_PROG_MIN   = 12'h003;
  localparam logic [3:0]  FRAC_MAX_M15  = 4'he;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         CLK_PERIOD_NS = 100;
  localparam logic [7:0] LOCK_ENTER_NS = 8'h0f;
  localparam logic [7:0] LOCK_EXIT_NS  = 8'h1e;
  localparam logic [2:0] LOCK_CYCLES   = 3'h5;
  localparam int         LINK_HALF_NS  = 400;
  localparam int         LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // host command registers
  // ----------------------------------------
  localparam logic [1:0] REG_WORD     = 2'h0;
  localparam logic [1:0] REG_CTRL     = 2'h1;
  localparam logic [1:0] REG_STATUS   = 2'h2;
  localparam int         CTRL_GO_BIT  = 0;
  localparam int         ST_BUSY_BIT  = 0;
  localparam int         ST_REFUSE_BIT = 1;

  // total divide value of an rf word: base * coarse + 4 * b + a
  function automatic logic [15:0] rf_total(input logic [23:0] w);
    logic [15:0] base;
    base = w[PRESC_BIT] ? BASE_HIGH : BASE_LOW;
    return 16'(base * {5'h00, w[COARSE_LSB +: 11]}) + {12'h000, w[BCNT_LSB +: 2], 2'h0}
           + {14'h0000, w[ACNT_LSB +: 2]};
  endfunction

  // coarse at least 3 and at least max(a, b) + 2
  function automatic logic rf_legal(input logic [23:0] w);
    logic [10:0] big;
    big = (w[BCNT_LSB +: 2] > w[ACNT_LSB +: 2]) ? {9'h000, w[BCNT_LSB +: 2]}
                                                 : {9'h000, w[ACNT_LSB +: 2]};
    return (w[COARSE_LSB +: 11] >= MIN_COARSE) && (w[COARSE_LSB +: 11] >= big + COARSE_MARGIN);
  endfunction
endpackage

// File: design/rfn_link_if.sv
`timescale 1ns/1ps
interface rfn_link_if;
  logic sclk;
  logic sdata;
  logic load_en;
  modport host (output sclk, output sdata, output load_en);
  modport dev  (input sclk, input sdata, input load_en);
endinterface

// File: design/rfn_sync.sv
`timescale 1ns/1ps
module rfn_sync #(
  parameter int W = 3
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] q1;
    logic [W-1:0] q2;
    logic [W-1:0] q3;
    logic [W-1:0] out;
  } rfn_sync_s;

  rfn_sync_s st_reg;
  rfn_sync_s st_next;

  // three stages; output moves once stages two and three agree
  always_comb begin
    st_next    = st_reg;
    st_next.q1 = din;
    st_next.q2 = st_reg.q1;
    st_next.q3 = st_reg.q2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.q2[i] == st_reg.q3[i]) begin
        st_next.out[i] = st_reg.q3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.out;
endmodule

// File: design/rfn_device.sv
// Contract
// - host keeps if program count 3..4095
// - control bits 11 load rf word
// - rf word fields at documented bit positions
// - host keeps coarse >= max(a,b)+2
// - total divide = base*coarse + 4b + a
// - counter clear holds n and r counters
// - n and r restart together after hold
// - prescaler select picks base 8 or 16
// - low set spans 40 to 16383
// - high set spans 80 to 32767
// - fraction 15 illegal under modulus 15
// - sleep stops counters, floats inputs, pump
// - reference input floats when both sleep
// - shifting and latching work while asleep
// - if word bit 21 selects sleep timing
// - host writes timing before sleep bit
// - synchronous sleep waits for pump pulse end
// - asynchronous sleep takes effect at once
// - msb first, sampled on rising clock
// - lock after 5 cycles under 15 ns
// - locked window widens to 30 ns
// - lock forced low while asleep
// - control bits 01 load if word
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module rfn_device (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        ce,
  rfn_link_if.dev          link,
  input  wire logic        frac_mod15,
  input  wire logic        rf_cp_pulse,
  input  wire logic        if_cp_pulse,
  input  wire logic        ref_tick,
  input  wire logic [7:0]  phase_err_ns,
  output logic      [10:0] rf_coarse_count,
  output logic      [1:0]  rf_b_count,
  output logic      [1:0]  rf_a_count,
  output logic      [3:0]  fraction_numerator,
  output logic             prescaler_modulus_select,
  output logic      [15:0] rf_total_divide_field,
  output logic             rf_divide_legal,
  output logic             fraction_legal,
  output logic      [11:0] if_program_count,
  output logic      [2:0]  if_swallow_count,
  output logic             sleep_timing_select,
  output logic             rf_loop_sleep,
  output logic             if_loop_sleep,
  output logic             rf_counter_hold,
  output logic             if_counter_hold,
  output logic             rf_counter_restart,
  output logic             if_counter_restart,
  output logic             reference_oscillator_input_hiz,
  output logic             monitor_lock_output
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [23:0] shift;
    logic [23:0] rf_word;
    logic        if_clear;
    logic        if_sleep_req;
    logic        timing;
    logic [11:0] if_prog;
    logic [2:0]  if_swallow;
    logic        sclk_q;
    logic        le_q;
    logic        rf_sleep;
    logic        if_sleep;
    logic        rf_hold;
    logic        if_hold;
    logic        rf_restart;
    logic        if_restart;
    logic        osc_hiz;
    logic [2:0]  good_cnt;
    logic        lock;
    logic [15:0] total;
    logic        legal;
    logic        frac_ok;
  } rfn_dev_s;

  rfn_dev_s   st_reg;
  rfn_dev_s   st_next;
  logic [2:0] pins;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  rfn_sync #(.W(3)) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .ce     (ce),
    .din    ({link.sclk, link.sdata, link.load_en}),
    .dout   (pins)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic sclk_s;
    logic data_s;
    logic le_s;
    logic rf_req;
    sclk_s = pins[2];
    data_s = pins[1];
    le_s   = pins[0];
    rf_req = 1'b0;

    st_next        = st_reg;
    st_next.sclk_q = sclk_s;
    st_next.le_q   = le_s;

    // shifter runs regardless of sleep state
    if (sclk_s && !st_reg.sclk_q) begin
      st_next.shift = {st_reg.shift[22:0], data_s}; // msb enters first
    end

    // latch transfer on the load strobe rising edge only
    if (le_s && !st_reg.le_q) begin
      if (st_reg.shift[1:0] == rfn_pkg::SEL_RF_N) begin
        st_next.rf_word = st_reg.shift;
      end else if (st_reg.shift[1:0] == rfn_pkg::SEL_IF_N) begin
        st_next.if_clear     = st_reg.shift[rfn_pkg::IF_CLEAR_BIT];
        st_next.if_sleep_req = st_reg.shift[rfn_pkg::IF_SLEEP_BIT];
        st_next.timing       = st_reg.shift[rfn_pkg::TIMING_BIT];
        st_next.if_prog      = st_reg.shift[rfn_pkg::IF_PROG_LSB +: 12];
        st_next.if_swallow   = st_reg.shift[rfn_pkg::IF_SWALLOW_LSB +: 3];
      end
    end

    // derived divide value and legality from the latched word
    st_next.total   = rfn_pkg::rf_total(st_reg.rf_word);
    st_next.legal   = rfn_pkg::rf_legal(st_reg.rf_word);
    st_next.frac_ok = !frac_mod15 ||
                      (st_reg.rf_word[rfn_pkg::FRAC_LSB +: 4] <= rfn_pkg::FRAC_MAX_M15);

    // sleep entry: synchronous waits for a quiet pump, asynchronous is immediate
    rf_req = st_reg.rf_word[rfn_pkg::RF_SLEEP_BIT];
    if (!rf_req) begin
      st_next.rf_sleep = 1'b0;
    end else if (!st_reg.timing || !rf_cp_pulse) begin
      st_next.rf_sleep = 1'b1;
    end
    if (!st_reg.if_sleep_req) begin
      st_next.if_sleep = 1'b0;
    end else if (!st_reg.timing || !if_cp_pulse) begin
      st_next.if_sleep = 1'b1;
    end
    st_next.osc_hiz = st_reg.rf_sleep && st_reg.if_sleep;

    // counters held by clear or sleep; one restart pulse to n and r together
    st_next.rf_hold    = st_reg.rf_word[rfn_pkg::RF_CLEAR_BIT] || st_reg.rf_sleep;
    st_next.if_hold    = st_reg.if_clear || st_reg.if_sleep;
    st_next.rf_restart = st_reg.rf_hold && !st_next.rf_hold;
    st_next.if_restart = st_reg.if_hold && !st_next.if_hold;

    // digital lock filter on each reference cycle
    if (st_reg.rf_sleep) begin
      st_next.lock     = 1'b0;
      st_next.good_cnt = 3'h0;
    end else if (ref_tick) begin
      if (st_reg.lock) begin
        if (phase_err_ns > rfn_pkg::LOCK_EXIT_NS) begin
          st_next.lock     = 1'b0;
          st_next.good_cnt = 3'h0;
        end
      end else if (phase_err_ns < rfn_pkg::LOCK_ENTER_NS) begin
        if (st_reg.good_cnt == rfn_pkg::LOCK_CYCLES - 3'h1) begin
          st_next.lock = 1'b1;
        end else begin
          st_next.good_cnt = st_reg.good_cnt + 3'h1;
        end
      end else begin
        st_next.good_cnt = 3'h0;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rf_coarse_count                = st_reg.rf_word[rfn_pkg::COARSE_LSB +: 11];
  assign rf_b_count                     = st_reg.rf_word[rfn_pkg::BCNT_LSB +: 2];
  assign rf_a_count                     = st_reg.rf_word[rfn_pkg::ACNT_LSB +: 2];
  assign fraction_numerator             = st_reg.rf_word[rfn_pkg::FRAC_LSB +: 4];
  assign prescaler_modulus_select       = st_reg.rf_word[rfn_pkg::PRESC_BIT];
  assign rf_total_divide_field          = st_reg.total;
  assign rf_divide_legal                = st_reg.legal;
  assign fraction_legal                 = st_reg.frac_ok;
  assign if_program_count               = st_reg.if_prog;
  assign if_swallow_count               = st_reg.if_swallow;
  assign sleep_timing_select            = st_reg.timing;
  assign rf_loop_sleep                  = st_reg.rf_sleep;
  assign if_loop_sleep                  = st_reg.if_sleep;
  assign rf_counter_hold                = st_reg.rf_hold;
  assign if_counter_hold                = st_reg.if_hold;
  assign rf_counter_restart             = st_reg.rf_restart;
  assign if_counter_restart             = st_reg.if_restart;
  assign reference_oscillator_input_hiz = st_reg.osc_hiz;
  assign monitor_lock_output            = st_reg.lock;
endmodule

// File: design/rfn_host.sv
`timescale 1ns/1ps
module rfn_host (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic [1:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  rfn_link_if.host         link
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_LOAD  = 3'h4
  } rfn_host_e;

  typedef struct packed {
    rfn_host_e   fsm;
    logic [23:0] word;
    logic [23:0] shift;
    logic [4:0]  bits;
    logic [7:0]  div;
    logic        sclk;
    logic        sdata;
    logic        le;
    logic        refused;
    logic [31:0] rdata;
  } rfn_host_s;

  rfn_host_s st_reg;
  rfn_host_s st_next;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic ok;
    logic half;
    ok   = 1'b1;
    half = (st_reg.div == 8'(rfn_pkg::LINK_HALF_CYC - 1));
    st_next       = st_reg;
    st_next.rdata = 32'h0000_0000;

    // refuse words that break divider limits
    if (st_reg.word[1:0] == rfn_pkg::SEL_RF_N) begin
      ok = rfn_pkg::rf_legal(st_reg.word);
    end else if (st_reg.word[1:0] == rfn_pkg::SEL_IF_N) begin
      ok = st_reg.word[rfn_pkg::IF_PROG_LSB +: 12] >= rfn_pkg::IF_PROG_MIN;
    end

    // register port
    if (wr && addr == rfn_pkg::REG_WORD && st_reg.fsm == ST_IDLE) begin
      st_next.word = wdata[23:0];
    end
    if (rd) begin
      case (addr)
        rfn_pkg::REG_WORD:   st_next.rdata = {8'h00, st_reg.word};
        rfn_pkg::REG_STATUS: st_next.rdata = {30'h0, st_reg.refused, st_reg.fsm != ST_IDLE};
        default:             st_next.rdata = 32'h0000_0000;
      endcase
    end

    // transfer engine; word order across writes is software's duty
    case (st_reg.fsm)
      ST_IDLE: begin
        if (wr && addr == rfn_pkg::REG_CTRL && wdata[rfn_pkg::CTRL_GO_BIT]) begin
          if (ok) begin
            st_next.fsm     = ST_SHIFT;
            st_next.shift   = st_reg.word;
            st_next.sdata   = st_reg.word[23]; // msb first
            st_next.bits    = 5'h00;
            st_next.div     = 8'h00;
            st_next.refused = 1'b0;
          end else begin
            st_next.refused = 1'b1;
          end
        end
      end
      ST_SHIFT: begin
        st_next.div = st_reg.div + 8'h01;
        if (half) begin
          st_next.div  = 8'h00;
          st_next.sclk = !st_reg.sclk; // data stable around rising edge
          if (st_reg.sclk) begin
            st_next.shift = {st_reg.shift[22:0], 1'b0};
            st_next.sdata = st_reg.shift[22];
            st_next.bits  = st_reg.bits + 5'h01;
            if (st_reg.bits == 5'(rfn_pkg::WORD_W - 1)) begin
              st_next.fsm   = ST_LOAD;
              st_next.sdata = 1'b0;
            end
          end
        end
      end
      ST_LOAD: begin
        st_next.le  = 1'b1;
        st_next.div = st_reg.div + 8'h01;
        if (st_reg.le && half) begin
          st_next.le  = 1'b0;
          st_next.div = 8'h00;
          st_next.fsm = ST_IDLE;
        end
      end
      default: begin
        st_next.fsm = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg     <= '0;
      st_reg.fsm <= ST_IDLE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign rdata        = st_reg.rdata;
  assign link.sclk    = st_reg.sclk;
  assign link.sdata   = st_reg.sdata;
  assign link.load_en = st_reg.le;
endmodule

// File: verif/rfn_link_sva.sv
`timescale 1ns/1ps
module rfn_link_sva (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       sclk,
  input wire logic       sdata,
  input wire logic       load_en,
  input wire logic       ref_tick,
  input wire logic [7:0] phase_err_ns,
  input wire logic       rf_cp_pulse,
  input wire logic       sleep_timing_select,
  input wire logic       rf_loop_sleep,
  input wire logic       if_loop_sleep,
  input wire logic       rf_counter_hold,
  input wire logic       rf_counter_restart,
  input wire logic       if_counter_hold,
  input wire logic       if_counter_restart,
  input wire logic       reference_oscillator_input_hiz,
  input wire logic       monitor_lock_output
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // helper: run of quiet reference ticks
  // ----------------------------------------
  logic [2:0] quiet_reg;
  logic [2:0] quiet_next;
  // count ticks under the entry window, saturating
  always_comb begin
    quiet_next = quiet_reg;
    if (ref_tick && phase_err_ns < rfn_pkg::LOCK_ENTER_NS) begin
      quiet_next = (quiet_reg == 3'h7) ? quiet_reg : quiet_reg + 3'h1;
    end else if (ref_tick) begin
      quiet_next = 3'h0;
    end
  end
  // helper register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      quiet_reg <= 3'h0;
    end else begin
      quiet_reg <= quiet_next;
    end
  end
  // ----------------------------------------
  // link and loop checks
  // ----------------------------------------
  chk_sclk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  chk_data_steady: assert property (sclk |-> $stable(sdata))
    else $error("serial data moved while clock high");
  chk_load_idle: assert property (load_en |-> !sclk)
    else $error("load strobe with serial clock high");
  chk_load_length: assert property ($rose(load_en) |-> load_en [*3] ##1 !load_en)
    else $error("load strobe length wrong");
  chk_lock_entry: assert property ($rose(monitor_lock_output) |-> quiet_reg >= 3'h5)
    else $error("lock rose before five quiet ticks");
  chk_lock_exit: assert property (monitor_lock_output && ref_tick
    && phase_err_ns > rfn_pkg::LOCK_EXIT_NS |-> ##[1:2] !monitor_lock_output)
    else $error("lock kept past wide window");
  chk_sleep_unlock: assert property (rf_loop_sleep ##1 rf_loop_sleep |-> !monitor_lock_output)
    else $error("lock high while asleep");
  chk_osc_float: assert property (reference_oscillator_input_hiz |->
    (rf_loop_sleep || $past(rf_loop_sleep)) && (if_loop_sleep || $past(if_loop_sleep)))
    else $error("reference input floats with a loop awake");
  chk_osc_both: assert property (rf_loop_sleep && if_loop_sleep
    |-> ##[0:1] reference_oscillator_input_hiz)
    else $error("reference input driven with both loops asleep");
  chk_sync_gate: assert property ($rose(rf_loop_sleep) && sleep_timing_select
    |-> !$past(rf_cp_pulse))
    else $error("synchronous sleep during pump pulse");
  chk_restart_fire: assert property ($fell(rf_counter_hold) |-> ##[0:1] rf_counter_restart)
    else $error("no restart after counter hold");
  chk_restart_once: assert property (rf_counter_restart |=> !rf_counter_restart)
    else $error("restart pulse too long");
  chk_if_restart: assert property ($fell(if_counter_hold) |-> if_counter_restart)
    else $error("no restart after if counter hold");
  // main scenarios reached
  cover property ($rose(monitor_lock_output));
  cover property ($rose(rf_loop_sleep) && sleep_timing_select);
  cover property (rf_counter_restart);
  cover property ($rose(reference_oscillator_input_hiz));
endmodule

// File: verif/rf_n_divider_programming_tb_top.sv
`timescale 1ns/1ps
module rf_n_divider_programming_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        frac_mod15 = 1'b0;
  logic        rf_cp_pulse = 1'b0;
  logic        ref_tick = 1'b0;
  logic [7:0]  phase_err_ns = 8'h00;
  logic [31:0] rdata;
  logic [10:0] rf_coarse_count;
  logic [1:0]  rf_b_count;
  logic [1:0]  rf_a_count;
  logic [3:0]  fraction_numerator;
  logic [15:0] rf_total_divide_field;
  logic [11:0] if_program_count;
  logic [2:0]  if_swallow_count;
  logic        prescaler_modulus_select, rf_divide_legal, fraction_legal, sleep_timing_select;
  logic        rf_loop_sleep, if_loop_sleep, rf_counter_hold, if_counter_hold;
  logic        rf_counter_restart, reference_oscillator_input_hiz, monitor_lock_output;
  logic        if_counter_restart;
  logic [63:0] got_vec;
  logic [63:0] expq[$];
  logic [23:0] rf_w = 24'h0;
  logic [23:0] if_w = 24'h0;
  logic [31:0] seed = 32'h544c07f6;
  logic [16:0] lim[4] = '{17'h00028, 17'h03fff, 17'h10050, 17'h17fff};
  int          err_total = 0;
  int          n_compared = 0;

  rfn_link_if rfn_link_if_i ();
  rfn_host rfn_host_i (.clock, .arst_n, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata,
    .link(rfn_link_if_i.host));
  rfn_device rfn_device_i (.clock, .arst_n, .ce(1'b1), .link(rfn_link_if_i.dev), .frac_mod15,
    .rf_cp_pulse, .if_cp_pulse(rf_cp_pulse), .ref_tick, .phase_err_ns, .rf_coarse_count,
    .rf_b_count, .rf_a_count, .fraction_numerator, .prescaler_modulus_select,
    .rf_total_divide_field, .rf_divide_legal, .fraction_legal, .if_program_count,
    .if_swallow_count, .sleep_timing_select, .rf_loop_sleep, .if_loop_sleep, .rf_counter_hold,
    .if_counter_hold, .rf_counter_restart, .if_counter_restart, .reference_oscillator_input_hiz,
    .monitor_lock_output);
  rfn_link_sva rfn_link_sva_i (.clock, .arst_n, .sclk(rfn_link_if_i.sclk),
    .sdata(rfn_link_if_i.sdata), .load_en(rfn_link_if_i.load_en), .ref_tick, .phase_err_ns,
    .rf_cp_pulse, .sleep_timing_select, .rf_loop_sleep, .if_loop_sleep, .rf_counter_hold,
    .rf_counter_restart, .if_counter_hold, .if_counter_restart,
    .reference_oscillator_input_hiz, .monitor_lock_output);

  // latched fields as one vector
  assign got_vec = {6'h00, rf_coarse_count, rf_b_count, rf_a_count, fraction_numerator,
    prescaler_modulus_select, rf_total_divide_field, rf_divide_legal, fraction_legal,
    rf_counter_hold, rf_loop_sleep, if_program_count, if_swallow_count, sleep_timing_select,
    if_counter_hold, if_loop_sleep};

  // clock and reset
  always #50 clock = ~clock;
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [23:0] rfw(input logic [2:0] ctl, input int n, input logic [3:0] fr);
    int p;
    int c;
    p = ctl[0] ? 16 : 8;
    c = n / p;
    return {ctl, 11'(c), 2'((n - c * p) / 4), 2'(n % 4), fr, 2'h3};
  endfunction

  function automatic logic [23:0] ifw(input logic [2:0] ctl, input int pc, input int sw);
    return {ctl, 4'h0, 12'(pc), 3'(sw), 2'h1};
  endfunction

  // expected outputs from the latched words
  function automatic logic [63:0] expect_of(input logic [23:0] r, input logic [23:0] f);
    logic [15:0] p;
    logic [15:0] tot;
    logic        rsl;
    logic        isl;
    p   = r[21] ? 16'h0010 : 16'h0008;
    tot = p * {5'h00, r[20:10]} + {12'h000, r[9:8], 2'h0} + {14'h0000, r[7:6]};
    rsl = r[22] & !(f[21] & rf_cp_pulse);
    isl = f[22] & !(f[21] & rf_cp_pulse);
    return {6'h00, r[20:10], r[9:8], r[7:6], r[5:2], r[21], tot, 1'b1,
            !(frac_mod15 && r[5:2] == 4'hf), r[23] | rsl, rsl,
            f[16:5], f[4:2], f[21], f[23] | isl, isl};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask

  // load a word, note the expected latch state, wait for the transfer
  task automatic send(input logic [23:0] w, input logic ok);
    logic [31:0] s;
    int k;
    wr_reg(rfn_pkg::REG_WORD, {8'h00, w});
    wr_reg(rfn_pkg::REG_CTRL, 32'h0000_0001);
    if (ok && w[1:0] == rfn_pkg::SEL_RF_N) rf_w = w;
    if (ok && w[1:0] == rfn_pkg::SEL_IF_N) if_w = w;
    if (ok) expq.push_back(expect_of(rf_w, if_w));
    k = 0;
    do begin
      rd_reg(rfn_pkg::REG_STATUS, s);
      k++;
    end while (s[0] !== 1'b0 && k < 400);
    chk(s, {30'h0, !ok, 1'b0});
    repeat (12) @(posedge clock);
  endtask

  task automatic tick(input logic [7:0] e);
    @(posedge clock);
    ref_tick     <= 1'b1;
    phase_err_ns <= e;
    @(posedge clock);
    ref_tick     <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // monitor: compare after each transfer
  // ----------------------------------------
  initial forever begin
    @(negedge rfn_link_if_i.load_en);
    if (arst_n === 1'b1) begin
      repeat (8) @(posedge clock);
      if (expq.size() == 0) chk(64'h0, 64'h1);
      else chk(got_vec, expq.pop_front());
    end
  end

  // watchdog
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] s;
    logic [23:0] w;
    int n;
    @(posedge arst_n);
    rd_reg(2'h3, s);
    chk(s, 32'h0);
    wr_reg(rfn_pkg::REG_WORD, 32'hffab_cdef);
    rd_reg(rfn_pkg::REG_WORD, s);
    chk(s, 32'h00ab_cdef);
    // divide range ends of both prescaler sets
    foreach (lim[i]) send(rfw({2'b00, lim[i][16]}, int'(lim[i][15:0]), 4'h1), 1'b1);
    // random divide values, fractions and moduli
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      frac_mod15 <= seed[30];
      n = seed[31] ? 80 + int'(seed[23:0] % 32688) : 40 + int'(seed[23:0] % 16344);
      send(rfw({2'b00, seed[31]}, n, seed[7:4]), 1'b1);
    end
    send(rfw(3'b000, 16, 4'h0), 1'b0);
    send(ifw(3'b000, 2, 0), 1'b0);
    send(ifw(3'b000, 3, 7), 1'b1);
    send(ifw(3'b000, 4095, 0), 1'b1);
    w = rfw(3'b000, 500, 4'h3);
    w[1:0] = 2'b10;
    send(w, 1'b1);
    frac_mod15 <= 1'b1;
    send(rfw(3'b000, 100, 4'hf), 1'b1);
    send(rfw(3'b100, 100, 4'h0), 1'b1);
    send(rfw(3'b000, 100, 4'h0), 1'b1);
    // lock filter: enter, widened window, exit, re-enter
    for (int i = 0; i < 18; i++) begin
      tick((i == 4 || i == 10 || i == 12) ? 8'h14 : (i == 11) ? 8'h28 : 8'h05);
      chk(monitor_lock_output, (i == 9 || i == 10 || i == 17));
    end
    // asynchronous sleep of both loops
    send(rfw(3'b010, 200, 4'h0), 1'b1);
    chk(monitor_lock_output, 1'b0);
    send(ifw(3'b010, 5, 0), 1'b1);
    chk(reference_oscillator_input_hiz, 1'b1);
    send(rfw(3'b000, 200, 4'h0), 1'b1);
    chk(reference_oscillator_input_hiz, 1'b0);
    // synchronous sleep held off by a pump pulse
    send(ifw(3'b100, 9, 2), 1'b1);
    send(ifw(3'b001, 5, 0), 1'b1);
    rf_cp_pulse <= 1'b1;
    send(rfw(3'b010, 300, 4'h0), 1'b1);
    rf_cp_pulse <= 1'b0;
    repeat (4) @(posedge clock);
    chk(rf_loop_sleep, 1'b1);
    send(rfw(3'b000, 300, 4'h0), 1'b1);
    summarize();
  end
endmodule
